// ---- include/smb_status_map.vh ----
// Constants for the SMBus slave status-read block
// Assumes inclusion by bare name from design files
`ifndef SMB_STATUS_MAP_VH
`define SMB_STATUS_MAP_VH
`define REG_RESERVED_SLOT 8'h00
`define REG_SLEEP_STATE_REPORT 8'h01
`define REG_STRAP_READBACK 8'h02
`define REG_WATCHDOG_COUNT_READBACK 8'h03
`define REG_EVENT_FLAGS 8'h04
`define EVT_INTRUSION_BIT 0
`define EVT_THERMAL_BIT 1
`define EVT_BOOT_FAIL_BIT 2
`define EVT_SECOND_EXPIRY_BIT 3
`define EVT_ALERT_BIT 7
`define SLEEP_S0 3'h0
`define SLEEP_S1 3'h1
`define SLEEP_S3 3'h3
`define SLEEP_S4 3'h4
`define SLEEP_S5 3'h5
`define MASTER_HOLDOFF_MS 1000
`define SLAVE_ADDR_RESET 7'h44
`endif

// ---- hw/sync2.v ----
// Two-flop synchroniser for one pin level
// Assumes async active-high reset, input from another domain
`timescale 1ns/100ps
`default_nettype none
module sync2 (
    input wire ref_clk,
    input wire rst,
    input wire d,
    output wire q
);
    reg meta_reg;
    reg sync_reg;
    // First flop read only by the second
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end
    assign q = sync_reg;
endmodule
`default_nettype wire

// ---- hw/status_mux.v ----
// Assembles the status byte for a register selector
// Assumes synchronised status inputs on ref_clk
`timescale 1ns/100ps
`default_nettype none
`include "smb_status_map.vh"
module status_mux (
    input wire [7:0] sel,
    input wire [2:0] sleep_state,
    input wire [3:0] freq_strap,
    input wire [5:0] watchdog_count,
    input wire cover_intrusion_flag,
    input wire thermal_alarm_active,
    input wire boot_failed,
    input wire first_expiry_flag,
    input wire second_expiry_flag,
    input wire alert_level,
    input wire input_polarity_select,
    output reg [7:0] status_byte
);
    // Reserved sleep codes read as zero
    function [2:0] legal_sleep;
        input [2:0] s;
        begin
            case (s)
                `SLEEP_S0, `SLEEP_S1, `SLEEP_S3, `SLEEP_S4, `SLEEP_S5: legal_sleep = s;
                default: legal_sleep = 3'h0;
            endcase
        end
    endfunction
    // Register selection, reserved fields zero
    always @* begin
        status_byte = 8'h00;
        case (sel)
            `REG_SLEEP_STATE_REPORT: begin
                status_byte[2:0] = legal_sleep(sleep_state);
            end
            `REG_STRAP_READBACK: begin
                status_byte[3:0] = freq_strap;
            end
            `REG_WATCHDOG_COUNT_READBACK: begin
                status_byte[5:0] = watchdog_count;
            end
            `REG_EVENT_FLAGS: begin
                status_byte[`EVT_INTRUSION_BIT] = cover_intrusion_flag;
                status_byte[`EVT_THERMAL_BIT] = thermal_alarm_active;
                status_byte[`EVT_BOOT_FAIL_BIT] = boot_failed;
                status_byte[`EVT_SECOND_EXPIRY_BIT] = first_expiry_flag & second_expiry_flag;
                status_byte[`EVT_ALERT_BIT] = input_polarity_select ? alert_level : ~alert_level;
            end
            default: begin
                status_byte = 8'h00;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- hw/smbus_slave_status_read.v ----
// SMBus slave byte-read engine returning one status byte
// Assumes scl/sda pins sampled on ref_clk (50 MHz), open-drain sda
`timescale 1ns/100ps
`default_nettype none
`include "smb_status_map.vh"
module smbus_slave_status_read (
    input wire ref_clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [6:0] recv_slave_addr,
    input wire [2:0] sleep_state,
    input wire [3:0] freq_strap,
    input wire [5:0] watchdog_count,
    input wire cover_intrusion_flag,
    input wire thermal_alarm_input,
    input wire thermal_polarity_select,
    input wire boot_failed,
    input wire first_expiry_flag,
    input wire second_expiry_flag,
    input wire alert_input_pin,
    input wire input_polarity_select,
    output reg [7:0] command_sel,
    output reg busy
);
    // One-hot states
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_ACK = 7'h04;
    localparam [6:0] ST_CMD = 7'h08;
    localparam [6:0] ST_WAIT_RS = 7'h10;
    localparam [6:0] ST_DATA = 7'h20;
    localparam [6:0] ST_MACK = 7'h40;

    wire scl_s;
    wire sda_s;
    wire alert_s;
    wire thermal_alarm_input_s;
    reg scl_d_reg;
    reg sda_d_reg;
    reg [6:0] state_reg;
    reg [6:0] state_next;
    reg [3:0] bit_cnt_reg;
    reg [3:0] bit_cnt_next;
    reg [7:0] shift_reg;
    reg [7:0] shift_next;
    reg [7:0] cmd_next;
    reg second_addr_reg;
    reg second_addr_next;
    reg drive_low_reg;
    reg drive_low_next;
    reg [7:0] tx_reg;
    reg [7:0] tx_next;
    wire [7:0] status_byte;

    // Pin synchronisers
    sync2 u_sync_scl (.ref_clk(ref_clk), .rst(rst), .d(scl_in), .q(scl_s));
    sync2 u_sync_sda (.ref_clk(ref_clk), .rst(rst), .d(sda_in), .q(sda_s));
    sync2 u_sync_alert (.ref_clk(ref_clk), .rst(rst), .d(alert_input_pin), .q(alert_s));
    sync2 u_sync_thermal_alarm_input (.ref_clk(ref_clk), .rst(rst), .d(thermal_alarm_input), .q(thermal_alarm_input_s));

    // Status byte selection
    status_mux u_mux (
        .sel(command_sel),
        .sleep_state(sleep_state),
        .freq_strap(freq_strap),
        .watchdog_count(watchdog_count),
        .cover_intrusion_flag(cover_intrusion_flag),
        .thermal_alarm_active(thermal_alarm_input_s ^ thermal_polarity_select),
        .boot_failed(boot_failed),
        .first_expiry_flag(first_expiry_flag),
        .second_expiry_flag(second_expiry_flag),
        .alert_level(alert_s),
        .input_polarity_select(input_polarity_select),
        .status_byte(status_byte)
    );

    // Bus edge and condition detection
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // Open-drain data pin, only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = drive_low_reg;

    // Next-state logic
    always @* begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        cmd_next = command_sel;
        second_addr_next = second_addr_reg;
        drive_low_next = drive_low_reg;
        tx_next = tx_reg;
        if (stop_det) begin
            state_next = ST_IDLE;
            drive_low_next = 1'b0;
        end else if (start_det) begin
            // Start or repeated start
            state_next = ST_ADDR;
            bit_cnt_next = 4'h0;
            second_addr_next = (state_reg == ST_WAIT_RS);
            drive_low_next = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    drive_low_next = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == 4'h8) begin
                        // Direction bit ignored, address alone decides
                        if (shift_reg[7:1] == recv_slave_addr) begin
                            state_next = ST_ACK;
                            drive_low_next = 1'b1;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        if (second_addr_reg) begin
                            // Sample the byte once at data phase start
                            tx_next = {status_byte[6:0], 1'b0};
                            drive_low_next = ~status_byte[7];
                            state_next = ST_DATA;
                        end else begin
                            drive_low_next = 1'b0;
                            state_next = ST_CMD;
                        end
                    end
                end
                ST_CMD: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == 4'h8) begin
                        cmd_next = shift_reg;
                        drive_low_next = 1'b1;
                        state_next = ST_WAIT_RS;
                    end
                end
                ST_WAIT_RS: begin
                    if (scl_fall) begin
                        drive_low_next = 1'b0;
                    end
                end
                ST_DATA: begin
                    if (scl_fall) begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7) begin
                            drive_low_next = 1'b0;
                            state_next = ST_MACK;
                        end else begin
                            // MSB first shifting
                            drive_low_next = ~tx_reg[7];
                            tx_next = {tx_reg[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    // Falling SCL at the end of the master ack slot ends the cycle, ack or nack
                    if (scl_fall) begin
                        state_next = ST_IDLE;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    drive_low_next = 1'b0;
                end
            endcase
        end
    end

    // State registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            command_sel <= 8'h00;
            second_addr_reg <= 1'b0;
            drive_low_reg <= 1'b0;
            tx_reg <= 8'h00;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            command_sel <= cmd_next;
            second_addr_reg <= second_addr_next;
            drive_low_reg <= drive_low_next;
            tx_reg <= tx_next;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            busy <= (state_next != ST_IDLE);
        end
    end
endmodule
`default_nettype wire

// ---- verification/smbus_status_checker_sva.sv ----
// Port-level checks for the SMBus status-read slave
// Assumes SDA/SCL pins change at least one clock apart
`timescale 1ns/100ps
`default_nettype none
module smbus_status_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [7:0] command_sel,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Bus conditions, SCL high on two samples
    sequence bus_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
    sequence bus_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
    a_pull_low_only: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    a_start_goes_busy: assert property (bus_start |-> ##[1:6] busy)
        else $error("no busy after start");
    a_stop_goes_idle: assert property (bus_stop |-> ##[1:6] !busy)
        else $error("busy after stop");
    a_idle_no_drive: assert property (!busy |-> !sda_oe)
        else $error("sda driven while idle");
    a_drive_rise_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
        else $error("sda drive began with scl high");
    a_drive_hold_high: assert property (sda_oe && scl_in && $past(scl_in) |=> sda_oe)
        else $error("sda drive dropped with scl high");
    a_drive_drop_low: assert property ($fell(sda_oe) |-> !$past(scl_in))
        else $error("sda released with scl high");
    a_sel_only_busy: assert property (!$stable(command_sel) |-> busy)
        else $error("command_sel moved while idle");
endmodule
`default_nettype wire

// ---- verification/smbus_master_model.sv ----
// Behavioural SMBus master issuing byte reads
// Assumes SDA is resolved with a pull-up in the bench; SCL period 160 ns
`timescale 1ns/100ps
`default_nettype none
module smbus_master_model (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Bus idles released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One bit: SDA set mid-low, sampled mid-high
    task automatic clk_bit(input logic b, output logic s);
        #40 sda_low = !b;
        #40 scl = 1'b1;
        #40 s = sda;
        #40 scl = 1'b0;
    endtask
    // Byte MSB first, then the slave's ack slot
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    // Start, addr+dir, cmd, Sr, addr+r, data, nack, stop
    task automatic byte_read(input logic [6:0] a, input logic wbit, input logic [7:0] cmd,
                             output logic ok, output logic [7:0] d);
        logic a1, a2, a3, s;
        @(posedge ref_clk);
        #1 sda_low = 1'b1;
        #80 scl = 1'b0;
        put_byte({a, wbit}, a1);
        put_byte(cmd, a2);
        ok = a1;
        if (a1) begin
            #40 sda_low = 1'b0;
            #80 scl = 1'b1;
            #40 sda_low = 1'b1;
            #40 scl = 1'b0;
            put_byte({a, 1'b1}, a3);
            for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
            clk_bit(1'b1, s);
            ok = a1 & a2 & a3;
        end
        #40 sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
        #80;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_smbus_slave_status_read.sv ----
// Self-checking bench for the SMBus status-read slave
// Assumes the master model owns SCL; SDA is open drain with a pull-up
`timescale 1ns/100ps
`default_nettype none
module tb_smbus_slave_status_read;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] recv_slave_addr = 7'h2b;
    logic [2:0] sleep_state = 3'h0;
    logic [3:0] freq_strap = 4'h0;
    logic [5:0] watchdog_count = 6'h00;
    logic cover_intrusion_flag = 1'b0, thermal_alarm_input = 1'b0, thermal_polarity_select = 1'b0;
    logic boot_failed = 1'b0, first_expiry_flag = 1'b0, second_expiry_flag = 1'b0;
    logic alert_input_pin = 1'b0, input_polarity_select = 1'b0;
    logic ok;
    logic [7:0] d, v;
    logic [7:0] ev [8] = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h0c, 8'h08, 8'h42, 8'h21};
    wire logic scl, sda_low, sda_out, sda_oe, busy, sda;
    wire logic [7:0] command_sel;
    int n_errors = 0;
    int cmp_count = 0;
    // Wired-AND SDA with pull-up
    assign sda = !(sda_low || (sda_oe && !sda_out));
    always #10 ref_clk = !ref_clk;
    smbus_slave_status_read smbus_slave_status_read_inst (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .recv_slave_addr(recv_slave_addr),
        .sleep_state(sleep_state), .freq_strap(freq_strap), .watchdog_count(watchdog_count),
        .cover_intrusion_flag(cover_intrusion_flag), .thermal_alarm_input(thermal_alarm_input),
        .thermal_polarity_select(thermal_polarity_select), .boot_failed(boot_failed),
        .first_expiry_flag(first_expiry_flag), .second_expiry_flag(second_expiry_flag),
        .alert_input_pin(alert_input_pin), .input_polarity_select(input_polarity_select),
        .command_sel(command_sel), .busy(busy));
    smbus_master_model smbus_master_model_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // Status inputs change just after a clock edge
    task automatic set_in(input logic [20:0] x);
        @(posedge ref_clk);
        #1 {sleep_state, freq_strap, watchdog_count, cover_intrusion_flag, thermal_alarm_input,
            thermal_polarity_select, boot_failed, first_expiry_flag, second_expiry_flag,
            alert_input_pin, input_polarity_select} = x;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Full byte read with ack, data and selector checks
    task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
        smbus_master_model_inst.byte_read(recv_slave_addr, 1'b0, cmd, ok, d);
        chk("ack", 8'h01, {7'h0, ok});
        chk("data", e, d);
        chk("command_sel", cmd, command_sel);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            set_in({i[2:0], 18'h0});
            rd(8'h01, (i == 2 || i > 5) ? 8'h00 : {5'h0, i[2:0]});
        end
        $display("test sleep_state done");
        set_in({3'h0, 4'ha, 6'h2d, 8'h00});
        rd(8'h02, 8'h0a);
        rd(8'h03, 8'h2d);
        set_in({3'h0, 4'hf, 6'h3f, 8'h00});
        rd(8'h02, 8'h0f);
        rd(8'h03, 8'h3f);
        $display("test strap_watchdog done");
        foreach (ev[k]) begin
            v = ev[k];
            set_in({13'h0, v});
            rd(8'h04, {~(v[1] ^ v[0]), 3'h0, v[3] & v[2], v[4], v[6] ^ v[5], v[7]});
        end
        $display("test event_flags done");
        set_in(21'h1fffff);
        rd(8'h00, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'hff, 8'h00);
        $display("test reserved done");
        smbus_master_model_inst.byte_read(recv_slave_addr, 1'b1, 8'h03, ok, d);
        chk("dir_ack", 8'h01, {7'h0, ok});
        chk("dir_data", 8'h3f, d);
        smbus_master_model_inst.byte_read(recv_slave_addr ^ 7'h01, 1'b0, 8'h02, ok, d);
        chk("nomatch_ack", 8'h00, {7'h0, ok});
        chk("nomatch_sel", 8'h03, command_sel);
        $display("test address_match done");
        tally_and_finish();
    end
    // Hang limit
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
endmodule
bind smbus_slave_status_read smbus_status_checker smbus_status_checker_inst (.ref_clk(ref_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .command_sel(command_sel), .busy(busy));
`default_nettype wire
